// file: logic/gpic_top.sv
// gpic_top: i2c register slave with pin interrupt mask/status and pin setup
// assumes: open-drain sda/scl resolved outside; pins idle high after reset
`timescale 1ns/1ps
`include "gpic_cfg.svh"

// How it works
// RULE_01: each pin has an interrupt enable bit in bits 2..0 of the low enable byte.
// RULE_02: a set enable bit lets that pin's events reach the host, a clear one blocks them.
// RULE_03: enable bits 7..3 and the high enable byte are reserved, read zero and do nothing.
// RULE_04: each pin has an interrupt status bit in bits 2..0 of the low status byte.
// RULE_05: a pin event sets its status bit whatever the enable bit holds; the code sets it only for pins in general pin use (fn_r one).
// RULE_06: writing one clears a status bit, writing zero leaves it alone.
// RULE_07: each of the three pins is set up on its own as general pin or touch input.
// RULE_08: the host should make unused pins outputs to save power.
// RULE_09: the register pointer steps on each byte so low and high bytes follow in turn.
// RULE_10: bit 7 of the system enable and status bytes gathers pin events.
// RULE_11: a one in the function byte selects general pin use, a zero selects touch.
// RULE_12: a zero direction bit makes a pin input, a one output, and all are zero at reset; the code drives a pin out only when its fn_r bit is also one.
// RULE_13: status and enable are ANDed per pin and ORed into one pin event request.
module gpic_top
  import gpic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // general pins
  input wire logic [`GPIC_NPIN-1:0] gpio_i,
  output logic [`GPIC_NPIN-1:0] gpio_o,
  output logic [`GPIC_NPIN-1:0] gpio_oe,
  output logic [`GPIC_NPIN-1:0] touch_sel,
  // interrupt requests toward the system interrupt logic
  output logic pin_event_req,
  output logic sys_gpio_irq
);

  logic [`GPIC_SYNC_W-1:0] lvl;
  logic [`GPIC_SYNC_W-1:0] rise;
  logic [`GPIC_SYNC_W-1:0] fall;
  logic [`GPIC_NPIN-1:0] en_r;
  logic [`GPIC_NPIN-1:0] sta_r;
  logic [`GPIC_NPIN-1:0] set_r;
  logic [`GPIC_NPIN-1:0] dir_r;
  logic [`GPIC_NPIN-1:0] fn_r;
  logic sys_en_r;
  logic sys_sta_r;
  gpic_wr_t wr_r;
  gpic_state_t st_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic [2:0] bit_cnt_r;
  logic full_r;
  logic first_r;
  logic rw_r;
  logic nack_r;
  logic oe_r;

  // read data for one pointer value
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [2:0] en,
    input logic [2:0] sta, input logic [2:0] mon, input logic [2:0] set,
    input logic [2:0] dir, input logic [2:0] fn, input logic sen, input logic ssta);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `GPIC_SYS_EN: d = {sen, 7'h00};
      `GPIC_SYS_STA: d = {ssta, 7'h00};
      `GPIC_EN_LO: d = {5'h00, en};
      `GPIC_STA_LO: d = {5'h00, sta};
      `GPIC_MON_LO: d = {5'h00, mon};
      `GPIC_SET_LO: d = {5'h00, set};
      `GPIC_DIR_LO: d = {5'h00, dir};
      `GPIC_FN_LO: d = {5'h00, fn};
      default: d = 8'h00; // RULE_03
    endcase
    return d;
  endfunction : rd_mux

  // pin and bus synchroniser
  gpic_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw({sda_i, scl_i, gpio_i}),
    .lvl_r(lvl),
    .rise_r(rise),
    .fall_r(fall)
  );

  // bus conditions and decoded writes
  wire scl = lvl[`GPIC_SCL_BIT];
  wire sda = lvl[`GPIC_SDA_BIT];
  wire scl_rise = rise[`GPIC_SCL_BIT];
  wire scl_fall = fall[`GPIC_SCL_BIT];
  wire bus_start = fall[`GPIC_SDA_BIT] & scl;
  wire bus_stop = rise[`GPIC_SDA_BIT] & scl;
  wire addr_hit = (shift_r[7:1] == `GPIC_I2C_ADDR);
  wire [7:0] rd_byte = rd_mux(ptr_r, en_r, sta_r, lvl[2:0], set_r, dir_r, fn_r,
                              sys_en_r, sys_sta_r);
  wire [7:0] ptr_inc = ptr_r + 8'h01;
  wire wr_en_lo = wr_r.en && (wr_r.addr == `GPIC_EN_LO);
  wire wr_sta_lo = wr_r.en && (wr_r.addr == `GPIC_STA_LO);
  wire wr_set_lo = wr_r.en && (wr_r.addr == `GPIC_SET_LO);
  wire wr_dir_lo = wr_r.en && (wr_r.addr == `GPIC_DIR_LO);
  wire wr_fn_lo = wr_r.en && (wr_r.addr == `GPIC_FN_LO);
  wire wr_sys_en = wr_r.en && (wr_r.addr == `GPIC_SYS_EN);
  wire wr_sys_sta = wr_r.en && (wr_r.addr == `GPIC_SYS_STA);

  // pin events and status update, set beats clear
  wire [2:0] sta_set = (rise[2:0] | fall[2:0]) & fn_r; // RULE_05
  wire [2:0] sta_clr = wr_sta_lo ? wr_r.data[2:0] : 3'h0; // RULE_06
  wire [2:0] sta_nxt = (sta_r & ~sta_clr) | sta_set; // RULE_04
  wire sys_clr = wr_sys_sta & wr_r.data[`GPIC_SYS_GPIO_BIT];

  // pin outputs and event requests
  assign gpio_o = set_r;
  assign gpio_oe = dir_r & fn_r; // RULE_12
  assign touch_sel = ~fn_r; // RULE_11
  assign pin_event_req = |(sta_r & en_r); // RULE_02 RULE_13
  assign sys_gpio_irq = sys_sta_r & sys_en_r; // RULE_10
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;

  // register file; reserved bits and high bytes are never stored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      en_r <= `GPIC_EN_RST;
      sta_r <= `GPIC_STA_RST;
      set_r <= `GPIC_SET_RST;
      dir_r <= `GPIC_DIR_RST;
      fn_r <= `GPIC_FN_RST;
      sys_en_r <= `GPIC_SYS_EN_RST;
      sys_sta_r <= `GPIC_SYS_STA_RST;
    end
    else
    begin
      if (wr_en_lo) en_r <= wr_r.data[2:0]; // RULE_01
      sta_r <= sta_nxt;
      if (wr_set_lo) set_r <= wr_r.data[2:0];
      if (wr_dir_lo) dir_r <= wr_r.data[2:0]; // RULE_12
      if (wr_fn_lo) fn_r <= wr_r.data[2:0]; // RULE_07
      if (wr_sys_en) sys_en_r <= wr_r.data[`GPIC_SYS_GPIO_BIT];
      sys_sta_r <= (sys_sta_r & ~sys_clr) | pin_event_req; // RULE_10
    end
  end

  // i2c slave: bits taken on scl rise, driven after scl fall
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      full_r <= 1'b0;
      first_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
      wr_r <= '0;
    end
    else
    begin
      wr_r.en <= 1'b0;
      if (bus_start)
      begin
        st_r <= ST_ADDR;
        bit_cnt_r <= 3'h0;
        full_r <= 1'b0;
        first_r <= 1'b1;
        oe_r <= 1'b0;
      end
      else if (bus_stop)
      begin
        st_r <= ST_IDLE;
        oe_r <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (st_r == ST_ADDR || st_r == ST_WDATA || st_r == ST_RDATA)
        begin
          if (st_r != ST_RDATA) shift_r <= {shift_r[6:0], sda};
          bit_cnt_r <= bit_cnt_r + 3'h1;
          full_r <= (bit_cnt_r == 3'h7);
        end
        if (st_r == ST_RACK) nack_r <= sda;
      end
      else if (scl_fall)
      begin
        unique case (st_r)
          ST_IDLE: st_r <= ST_IDLE;
          ST_ADDR:
          begin
            if (full_r)
            begin
              st_r <= addr_hit ? ST_AACK : ST_IDLE;
              oe_r <= addr_hit;
              rw_r <= shift_r[0];
            end
          end
          ST_AACK, ST_RACK:
          begin
            full_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            if (st_r == ST_RACK && nack_r)
            begin
              st_r <= ST_IDLE;
              oe_r <= 1'b0;
            end
            else if (rw_r)
            begin
              st_r <= ST_RDATA;
              shift_r <= rd_byte;
              oe_r <= ~rd_byte[7];
            end
            else
            begin
              st_r <= ST_WDATA;
              oe_r <= 1'b0;
            end
          end
          ST_WDATA:
          begin
            if (full_r)
            begin
              st_r <= ST_WACK;
              oe_r <= 1'b1;
              first_r <= 1'b0;
              if (first_r)
                ptr_r <= shift_r;
              else
              begin
                wr_r <= '{en: 1'b1, addr: ptr_r, data: shift_r};
                ptr_r <= ptr_inc; // RULE_09
              end
            end
          end
          ST_WACK:
          begin
            st_r <= ST_WDATA;
            oe_r <= 1'b0;
            full_r <= 1'b0;
            bit_cnt_r <= 3'h0;
          end
          ST_RDATA:
          begin
            if (full_r)
            begin
              st_r <= ST_RACK;
              oe_r <= 1'b0;
              ptr_r <= ptr_inc; // RULE_09
            end
            else
            begin
              shift_r <= {shift_r[6:0], 1'b0};
              oe_r <= ~shift_r[6];
            end
          end
        endcase
      end
    end
  end

  // checks on the register file and event paths
  AST_EN_STORE: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    wr_en_lo |=> en_r == $past(wr_r.data[2:0]))
    else $error("enable bits not stored");
  AST_MASK_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    (en_r == 3'h0) |-> !pin_event_req)
    else $error("masked pin raised a request");
  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
    (ptr_r == `GPIC_EN_HI || ptr_r == `GPIC_STA_HI) |-> rd_byte == 8'h00)
    else $error("reserved byte reads nonzero");
  AST_STA_SET: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    (sta_set != 3'h0) |=> (sta_r & $past(sta_set)) == $past(sta_set))
    else $error("pin event lost");
  AST_W1C: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    (wr_sta_lo && sta_set == 3'h0) |=>
      sta_r == ($past(sta_r) & ~$past(wr_r.data[2:0])))
    else $error("status write one clear wrong");
  AST_PTR_STEP: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
    (scl_fall && !bus_start && !bus_stop && st_r == ST_RDATA && full_r) |=>
      ptr_r == $past(ptr_r) + 8'h01 ##1 st_r == ST_RACK)
    else $error("read pointer did not step");
  AST_SYS_GATHER: assert property (@(posedge sys_clk) disable iff (rst) // RULE_10
    pin_event_req |=> sys_sta_r && (!sys_en_r || sys_gpio_irq))
    else $error("system pin status not set");
  AST_FN_TOUCH: assert property (@(posedge sys_clk) disable iff (rst) // RULE_11
    wr_fn_lo |=> touch_sel == ~$past(wr_r.data[2:0]) && (gpio_oe & touch_sel) == 3'h0)
    else $error("function select wrong");
  AST_DIR_RESET: assert property (@(posedge sys_clk) // RULE_12
    $past(rst) |-> dir_r == 3'h0 && gpio_oe == 3'h0)
    else $error("direction not input after reset");
  AST_REQ_LATE: assert property (@(posedge sys_clk) disable iff (rst) // RULE_13
    ((sta_set & en_r) != 3'h0 && !wr_en_lo) |=> pin_event_req)
    else $error("enabled event gave no request");

endmodule : gpic_top

// file: logic/gpic_cfg.svh
// gpic_cfg.svh: register offsets, field positions, reset values, sizes
// assumes: included by bare name from the package and the design modules
`ifndef GPIC_CFG_SVH
`define GPIC_CFG_SVH

// register offsets on the i2c byte pointer
`define GPIC_SYS_EN 8'h09
`define GPIC_SYS_STA 8'h0A
`define GPIC_EN_LO 8'h0B
`define GPIC_EN_HI 8'h0C
`define GPIC_STA_LO 8'h0D
`define GPIC_STA_HI 8'h0E
`define GPIC_MON_LO 8'h10
`define GPIC_MON_HI 8'h11
`define GPIC_SET_LO 8'h12
`define GPIC_SET_HI 8'h13
`define GPIC_DIR_LO 8'h14
`define GPIC_DIR_HI 8'h15
`define GPIC_FN_LO 8'h16
`define GPIC_FN_HI 8'h17

// field positions and sizes
`define GPIC_NPIN 3
`define GPIC_SYS_GPIO_BIT 7
`define GPIC_SYNC_W 5
`define GPIC_SCL_BIT 3
`define GPIC_SDA_BIT 4
`define GPIC_PRIME_CNT 3'h4 // edges after reset before pin changes count

// reset values
`define GPIC_EN_RST 3'h0
`define GPIC_STA_RST 3'h0
`define GPIC_SET_RST 3'h0
`define GPIC_DIR_RST 3'h0
`define GPIC_FN_RST 3'h7
`define GPIC_SYS_EN_RST 1'h0
`define GPIC_SYS_STA_RST 1'h0

// i2c slave address, arbitrary value
`define GPIC_I2C_ADDR 7'h5A

`endif

// file: logic/gpic_pkg.sv
// gpic_pkg: types shared by the pin interrupt and configuration block
// assumes: gpic_cfg.svh sits on the include path
`include "gpic_cfg.svh"

package gpic_pkg;

  // register write request from the i2c side
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } gpic_wr_t;

  // i2c slave states, gray codes along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WDATA = 3'h2,
    ST_WACK = 3'h6,
    ST_RDATA = 3'h7,
    ST_RACK = 3'h5
  } gpic_state_t;

endpackage : gpic_pkg

// file: logic/gpic_pin_sync.sv
// gpic_pin_sync: three-stage synchroniser with agreement filter per pin
// assumes: raw inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`include "gpic_cfg.svh"

module gpic_pin_sync
  import gpic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // raw pins
  input wire logic [`GPIC_SYNC_W-1:0] raw,
  // filtered level and change pulses
  output logic [`GPIC_SYNC_W-1:0] lvl_r,
  output logic [`GPIC_SYNC_W-1:0] rise_r,
  output logic [`GPIC_SYNC_W-1:0] fall_r
);

  logic [`GPIC_SYNC_W-1:0] s1_r;
  logic [`GPIC_SYNC_W-1:0] s2_r;
  logic [`GPIC_SYNC_W-1:0] s3_r;
  logic [2:0] prime_r;
  wire armed = (prime_r == `GPIC_PRIME_CNT);
  wire [`GPIC_SYNC_W-1:0] agree = ~(s2_r ^ s3_r);
  wire [`GPIC_SYNC_W-1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
  // no edges until the chain holds real pin levels, so reset gives no false event
  wire [`GPIC_SYNC_W-1:0] rise_nxt = {`GPIC_SYNC_W{armed}} & lvl_nxt & ~lvl_r;
  wire [`GPIC_SYNC_W-1:0] fall_nxt = {`GPIC_SYNC_W{armed}} & ~lvl_nxt & lvl_r;

  // shift chain; a change counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      lvl_r <= '1;
      rise_r <= '0;
      fall_r <= '0;
      prime_r <= 3'h0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      if (!armed) prime_r <= prime_r + 3'h1;
    end
  end

endmodule : gpic_pin_sync

// file: verif/gpic_host.sv
// gpic_host: i2c master model standing in for the host processor
// assumes: sda has a pull-up and the bench resolves the wire
`timescale 1ns/1ps

module gpic_host
(
  // clock
  input wire logic sys_clk,
  // i2c wire
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // released lines idle high
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // quarter of an scl period, 5 cycles
  task automatic qtr(input int n);
    repeat (n * 5) @(negedge sys_clk);
  endtask : qtr

  // data moves mid-low, line sampled mid-high
  task automatic bit_io(input logic b, output logic seen);
    qtr(1);
    sda = b;
    qtr(1);
    scl = 1'b1;
    qtr(1);
    seen = sda_line;
    qtr(1);
    scl = 1'b0;
  endtask : bit_io

  // start or repeated start
  task automatic start();
    qtr(1);
    sda = 1'b1;
    qtr(1);
    scl = 1'b1;
    qtr(2);
    sda = 1'b0;
    qtr(2);
    scl = 1'b0;
  endtask : start

  // stop leaves both lines released
  task automatic stop();
    qtr(1);
    sda = 1'b0;
    qtr(1);
    scl = 1'b1;
    qtr(2);
    sda = 1'b1;
    qtr(2);
  endtask : stop

  // one byte out and in, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(mack, a);
    ack = ~a;
  endtask : xfer
endmodule : gpic_host

// file: verif/gpic_top_tb.sv
// gpic_top_tb: self-checking bench for the pin interrupt and setup block
// assumes: gpic_host drives i2c; sda pulled up; bench drives pins
`timescale 1ns/1ps
`include "gpic_cfg.svh"

module gpic_top_tb
  import gpic_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] gpio_i = 3'h0;
  logic scl, sda_m, sda_o, sda_oe, pin_event_req, sys_gpio_irq, ack;
  logic [2:0] gpio_o, gpio_oe, touch_sel;
  logic [7:0] q;
  logic [7:0] rd [3];
  int failures = 0;
  int n_compared = 0;
  // wired-and sda with pull-up
  wire sda_line = sda_m & ~(sda_oe & ~sda_o);
  // ordinary cases: pointer, written byte, byte read back
  logic [23:0] rows [6] = '{24'h0BFF07, 24'h0CFF00, 24'h0B0505, 24'h160303,
                            24'h140707, 24'h120505};

  always #5 sys_clk = ~sys_clk;

  gpic_top u_dut (.sys_clk(sys_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .touch_sel(touch_sel), .pin_event_req(pin_event_req),
    .sys_gpio_irq(sys_gpio_irq));

  gpic_host u_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // address phase plus pointer byte
  task automatic sel(input logic [7:0] ptr);
    u_host.start();
    u_host.xfer({`GPIC_I2C_ADDR, 1'b0}, 1'b1, q, ack);
    check({7'h0, ack}, 8'h01);
    u_host.xfer(ptr, 1'b1, q, ack);
    check({7'h0, ack}, 8'h01);
  endtask : sel

  task automatic regwr(input logic [7:0] ptr, input logic [23:0] d, input int n);
    sel(ptr);
    for (int i = 0; i < n; i++)
      u_host.xfer(d[23 - 8 * i -: 8], 1'b1, q, ack);
    u_host.stop();
  endtask : regwr

  task automatic regrd(input logic [7:0] ptr, input int n);
    sel(ptr);
    u_host.start();
    u_host.xfer({`GPIC_I2C_ADDR, 1'b1}, 1'b1, q, ack);
    check({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++)
      u_host.xfer(8'hFF, i == n - 1, rd[i], ack);
    u_host.stop();
  endtask : regrd

  // bounded wait on a request output
  task automatic wait_out(input logic sys, input logic exp);
    int k;
    k = 0;
    while (((sys ? sys_gpio_irq : pin_event_req) !== exp) && k < 30)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 30)
    begin
      failures++;
      results();
    end
  endtask : wait_out

  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({gpio_oe, touch_sel, pin_event_req, sys_gpio_irq}, 8'h00);
    regrd(8'h0B, 3);
    check(rd[0] | rd[1] | rd[2], 8'h00);
    regrd(8'h14, 1);
    check(rd[0], 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      regwr(rows[i][23:16], {rows[i][15:8], 16'h0}, 1);
      regrd(rows[i][23:16], 1);
      check(rd[0], rows[i][7:0]);
    end
    check({5'h0, gpio_oe}, 8'h03);
    check({5'h0, touch_sel}, 8'h04);
    check({5'h0, gpio_o}, 8'h05);
    $display("test table done");
    regwr(8'h14, 24'h01FF07, 3);
    regrd(8'h14, 3);
    check(rd[0], 8'h01);
    check(rd[1], 8'h00);
    check(rd[2], 8'h07);
    check({5'h0, gpio_oe}, 8'h01);
    regwr(8'h14, 24'h0, 1);
    regwr(8'h0B, 24'h0, 1);
    $display("test increment done");
    gpio_i = 3'h2;
    regrd(8'h0D, 2);
    check(rd[0], 8'h02);
    check(rd[1], 8'h00);
    check({7'h0, pin_event_req}, 8'h00);
    regwr(8'h0B, 24'h020000, 1);
    wait_out(1'b0, 1'b1);
    check({7'h0, pin_event_req}, 8'h01);
    regwr(8'h09, 24'h800000, 1);
    wait_out(1'b1, 1'b1);
    regrd(8'h09, 2);
    check(rd[0] & rd[1], 8'h80);
    regwr(8'h0D, 24'h050000, 1);
    regrd(8'h0D, 1);
    check(rd[0], 8'h02);
    regwr(8'h0D, 24'h020000, 1);
    wait_out(1'b0, 1'b0);
    regwr(8'h0A, 24'h800000, 1);
    regrd(8'h0A, 1);
    check(rd[0] | {7'h0, sys_gpio_irq}, 8'h00);
    regrd(8'h10, 2);
    check(rd[0] | rd[1], 8'h02);
    $display("test events done");
    regrd(8'h30, 1);
    check(rd[0], 8'h00);
    u_host.start();
    u_host.xfer({`GPIC_I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
    check({7'h0, ack}, 8'h00);
    u_host.stop();
    regwr(8'h0B, 24'h070000, 1);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    regrd(8'h0B, 1);
    check(rd[0], 8'h00);
    regrd(8'h0D, 1);
    check(rd[0], 8'h00);
    regrd(8'h16, 1);
    check(rd[0], 8'h07);
    $display("test refusal and reset done");
    results();
  end
endmodule : gpic_top_tb
